// >>> hdl/isd_pkg.sv
// Shared constants, types and decode tables for the initial speed detect block
package isd_pkg;

  // ---------------------------------------------------------------
  // Register placement and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'h80;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int RESYNC_LSB = 22;
  localparam int BRK_SIDE_BIT = 21;
  localparam int BRK_EXIT_BIT = 20;
  localparam int BRK_CURR_LSB = 17;
  localparam int BRAKE_DURATION_LSB = 13;
  localparam int HIGH_IMPEDANCE_DURATION_LSB = 9;
  localparam int BEMF_LSB = 6;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_IN_NS = 1000000;
  localparam int CYCLES_PER_MS_DFLT = MS_IN_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ISD_IDLE, ISD_COAST, ISD_BRAKE, ISD_DONE}
    isd_state_t;

  // ---------------------------------------------------------------
  // Decode tables
  // ---------------------------------------------------------------
  // Shared by the brake and the high impedance duration fields
  function automatic logic [13:0] isd_duration_ms(input logic [3:0] code);
    case (code)
      4'h0: isd_duration_ms = 14'h000A;
      4'h1: isd_duration_ms = 14'h0032;
      4'h2: isd_duration_ms = 14'h0064;
      4'h3: isd_duration_ms = 14'h00C8;
      4'h4: isd_duration_ms = 14'h012C;
      4'h5: isd_duration_ms = 14'h0190;
      4'h6: isd_duration_ms = 14'h01F4;
      4'h7: isd_duration_ms = 14'h02EE;
      4'h8: isd_duration_ms = 14'h03E8;
      4'h9: isd_duration_ms = 14'h07D0;
      4'hA: isd_duration_ms = 14'h0BB8;
      4'hB: isd_duration_ms = 14'h0FA0;
      4'hC: isd_duration_ms = 14'h1388;
      4'hD: isd_duration_ms = 14'h1D4C;
      4'hE: isd_duration_ms = 14'h2710;
      default: isd_duration_ms = 14'h3A98;
    endcase
  endfunction

  // Unlisted codes give zero, so the current comparison never fires
  function automatic logic [10:0] isd_current_ma(input logic [2:0] code);
    case (code)
      3'h0: isd_current_ma = 11'h064;
      3'h1: isd_current_ma = 11'h0C8;
      3'h2: isd_current_ma = 11'h12C;
      3'h3: isd_current_ma = 11'h1F4;
      3'h4: isd_current_ma = 11'h3E8;
      3'h5: isd_current_ma = 11'h7D0;
      default: isd_current_ma = 11'h000;
    endcase
  endfunction

  function automatic logic [10:0] isd_bemf_mv(input logic [2:0] code);
    case (code)
      3'h0: isd_bemf_mv = 11'h032;
      3'h1: isd_bemf_mv = 11'h04B;
      3'h2: isd_bemf_mv = 11'h064;
      3'h3: isd_bemf_mv = 11'h0FA;
      3'h4: isd_bemf_mv = 11'h1F4;
      3'h5: isd_bemf_mv = 11'h2EE;
      3'h6: isd_bemf_mv = 11'h3E8;
      default: isd_bemf_mv = 11'h5DC;
    endcase
  endfunction

  // Unlisted codes give 127%, so resync happens only at a full-scale speed input of 127
  function automatic logic [6:0] isd_resync_pct(input logic [3:0] code);
    case (code)
      4'h0: isd_resync_pct = 7'h05;
      4'h1: isd_resync_pct = 7'h0A;
      4'h2: isd_resync_pct = 7'h0F;
      4'h3: isd_resync_pct = 7'h14;
      4'h4: isd_resync_pct = 7'h19;
      4'h5: isd_resync_pct = 7'h1E;
      4'h6: isd_resync_pct = 7'h23;
      4'h7: isd_resync_pct = 7'h28;
      4'h8: isd_resync_pct = 7'h2D;
      4'h9: isd_resync_pct = 7'h32;
      default: isd_resync_pct = 7'h7F;
    endcase
  endfunction

endpackage

// >>> hdl/isd_ms_timer.sv
// Millisecond duration timer used for the coast and brake phases
module isd_ms_timer #(
  parameter int CYCLES_PER_MS = isd_pkg::CYCLES_PER_MS_DFLT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic [13:0] duration_ms,
  // Status
  output logic expired
);

  typedef struct packed {
    logic [31:0] pre;
    logic [13:0] ms;
    logic [13:0] target;
    logic run;
    logic expired;
  } isd_tmr_t;

  isd_tmr_t tmr_r;
  isd_tmr_t tmr_nxt;

  always_comb begin
    tmr_nxt = tmr_r;
    tmr_nxt.expired = 1'b0;
    // A fresh start always wins, so a stale run cannot expire a new phase
    if (start) begin
      tmr_nxt.pre = 32'h0000_0000;
      tmr_nxt.ms = 14'h0000;
      tmr_nxt.target = duration_ms;
      tmr_nxt.run = 1'b1;
    end else if (tmr_r.run) begin
      if (tmr_r.pre == 32'(CYCLES_PER_MS - 1)) begin
        tmr_nxt.pre = 32'h0000_0000;
        tmr_nxt.ms = tmr_r.ms + 14'h0001;
        if (tmr_r.ms + 14'h0001 == tmr_r.target) begin
          tmr_nxt.expired = 1'b1;
          tmr_nxt.run = 1'b0;
        end
      end else begin
        tmr_nxt.pre = tmr_r.pre + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  assign expired = tmr_r.expired;

endmodule

// >>> hdl/initial_speed_detect_config.sv
// Initial speed detect configuration word and startup sequencer
// How it works
// - Bits 25-22 pick resync speed, 5% to 50% in 5% steps.
// - Brake side bit 21: 0 all high side on, 1 all low side on.
// - Exit bit 0 leaves brake on time; both durations share one table.
// - Exit bit 1 leaves brake on current below threshold or on time.
// - Bits 8-6 pick back-EMF level below which motor counts stationary.
module initial_speed_detect_config #(
  parameter int CYCLES_PER_MS = isd_pkg::CYCLES_PER_MS_DFLT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_rd_en,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // Start request and motor measurements
  input wire logic isd_start,
  input wire logic [6:0] motor_speed_pct,
  input wire logic [10:0] backemf_mv,
  input wire logic [10:0] phase_current_ma,
  // Bridge control and result
  output logic [2:0] high_side_on,
  output logic [2:0] low_side_on,
  output logic phase_hiz,
  output logic isd_busy,
  output logic motor_stationary,
  output logic resync_ok,
  output logic isd_done
);

  typedef struct packed {
    logic [31:0] cfg;
    isd_pkg::isd_state_t st;
    logic [2:0] hs;
    logic [2:0] ls;
    logic hiz;
    logic stat;
    logic resync;
    logic done;
    logic [31:0] rdata;
    logic rvalid;
  } isd_regs_t;

  isd_regs_t regs_r;
  isd_regs_t regs_nxt;

  // ---------------------------------------------------------------
  // Field widths and gate patterns
  // ---------------------------------------------------------------
  localparam int RESYNC_W = 4;
  localparam int CURR_W = 3;
  localparam int TIME_W = 4;
  localparam int BEMF_W = 3;
  localparam logic [2:0] GATES_ALL = 3'h7;
  localparam logic [2:0] GATES_NONE = 3'h0;

  // Braking shorts all three phases through one side of the bridge
  function automatic logic [5:0] brake_gates(input logic low_side);
    if (low_side) begin
      brake_gates = {GATES_NONE, GATES_ALL};
    end else begin
      brake_gates = {GATES_ALL, GATES_NONE};
    end
  endfunction

  logic tmr_start;
  logic [13:0] tmr_ms;
  logic tmr_expired;

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  logic [3:0] resync_code;
  logic brake_side;
  logic brake_exit;
  logic [2:0] curr_code;
  logic [3:0] brake_duration_code;
  logic [3:0] high_impedance_duration_code;
  logic [2:0] bemf_code;
  logic below_bemf;
  logic above_resync;
  logic below_current;

  // Thresholds and exit mode changed mid-sequence take effect at once; durations and brake side latch at phase start
  assign resync_code = regs_r.cfg[isd_pkg::RESYNC_LSB +: RESYNC_W];
  assign brake_side = regs_r.cfg[isd_pkg::BRK_SIDE_BIT];
  assign brake_exit = regs_r.cfg[isd_pkg::BRK_EXIT_BIT];
  assign curr_code = regs_r.cfg[isd_pkg::BRK_CURR_LSB +: CURR_W];
  assign brake_duration_code = regs_r.cfg[isd_pkg::BRAKE_DURATION_LSB +: TIME_W];
  assign high_impedance_duration_code = regs_r.cfg[isd_pkg::HIGH_IMPEDANCE_DURATION_LSB +: TIME_W];
  assign bemf_code = regs_r.cfg[isd_pkg::BEMF_LSB +: BEMF_W];

  // Unusable current codes decode to a limit that is never met; unusable resync codes are met only at 127%

  assign below_bemf = backemf_mv < isd_pkg::isd_bemf_mv(bemf_code);
  assign above_resync =
    motor_speed_pct >= isd_pkg::isd_resync_pct(resync_code);
  assign below_current =
    phase_current_ma < isd_pkg::isd_current_ma(curr_code);

  // ---------------------------------------------------------------
  // Phase timer
  // ---------------------------------------------------------------
  isd_ms_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .duration_ms(tmr_ms),
    .expired(tmr_expired)
  );

  // ---------------------------------------------------------------
  // Register access and sequencer
  // ---------------------------------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.done = 1'b0;
    regs_nxt.rvalid = 1'b0;
    tmr_start = 1'b0;
    // Coast picks the brake duration ahead, since it starts the brake
    if (regs_r.st == isd_pkg::ISD_COAST) begin
      tmr_ms = isd_pkg::isd_duration_ms(brake_duration_code);
    end else begin
      tmr_ms = isd_pkg::isd_duration_ms(high_impedance_duration_code);
    end

    // Writes elsewhere are dropped; reads elsewhere answer zero
    if (cfg_wr_en && cfg_addr == isd_pkg::CFG_OFFSET) begin
      regs_nxt.cfg = cfg_wdata;
    end
    if (cfg_rd_en) begin
      regs_nxt.rvalid = 1'b1;
      if (cfg_addr == isd_pkg::CFG_OFFSET) begin
        regs_nxt.rdata = regs_r.cfg;
      end else begin
        regs_nxt.rdata = 32'h0000_0000;
      end
    end

    // A start while busy is ignored, so a sequence always runs to its end
    // and its result flags cannot be cleared halfway
    case (regs_r.st)
      isd_pkg::ISD_IDLE: begin
        if (isd_start) begin
          regs_nxt.st = isd_pkg::ISD_COAST;
          regs_nxt.hiz = 1'b1;
          regs_nxt.hs = 3'h0;
          regs_nxt.ls = 3'h0;
          regs_nxt.stat = 1'b0;
          regs_nxt.resync = 1'b0;
          tmr_start = 1'b1;
        end
      end
      isd_pkg::ISD_COAST: begin
        if (tmr_expired) begin
          if (below_bemf) begin
            regs_nxt.stat = 1'b1;
            regs_nxt.st = isd_pkg::ISD_DONE;
          end else if (above_resync) begin
            regs_nxt.resync = 1'b1;
            regs_nxt.st = isd_pkg::ISD_DONE;
          end else begin
            regs_nxt.st = isd_pkg::ISD_BRAKE;
            regs_nxt.hiz = 1'b0;
            {regs_nxt.hs, regs_nxt.ls} = brake_gates(brake_side);
            tmr_start = 1'b1;
          end
        end
      end
      isd_pkg::ISD_BRAKE: begin
        // Time always bounds the brake; current may end it sooner
        if (tmr_expired || (brake_exit && below_current)) begin
          regs_nxt.st = isd_pkg::ISD_DONE;
          regs_nxt.hs = 3'h0;
          regs_nxt.ls = 3'h0;
          regs_nxt.hiz = 1'b1;
          regs_nxt.stat = 1'b1;
        end
      end
      isd_pkg::ISD_DONE: begin
        regs_nxt.done = 1'b1;
        regs_nxt.st = isd_pkg::ISD_IDLE;
      end
      default: begin
        regs_nxt.st = isd_pkg::ISD_IDLE;
        regs_nxt.hs = 3'h0;
        regs_nxt.ls = 3'h0;
        regs_nxt.hiz = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_r <= '0;
      regs_r.cfg <= isd_pkg::CFG_RESET;
      regs_r.st <= isd_pkg::ISD_IDLE;
      regs_r.hiz <= 1'b1;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_rdata = regs_r.rdata;
  assign cfg_rd_valid = regs_r.rvalid;
  assign high_side_on = regs_r.hs;
  assign low_side_on = regs_r.ls;
  assign phase_hiz = regs_r.hiz;
  assign isd_busy = regs_r.st != isd_pkg::ISD_IDLE;
  assign motor_stationary = regs_r.stat;
  assign resync_ok = regs_r.resync;
  assign isd_done = regs_r.done;

endmodule

// >>> test/initial_speed_detect_config_props.sv
// Checker for the initial speed detect config word and sequencer
module initial_speed_detect_config_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Config bus
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_rd_en,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_valid,
  // Bridge and result
  input wire logic [2:0] high_side_on,
  input wire logic [2:0] low_side_on,
  input wire logic phase_hiz,
  input wire logic isd_busy,
  input wire logic motor_stationary,
  input wire logic resync_ok,
  input wire logic isd_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the stored word, rebuilt from the bus alone
  logic [31:0] word_r;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) word_r <= 32'h0;
    else if (cfg_wr_en && cfg_addr == 8'h80) word_r <= cfg_wdata;
  AST_RD_VALID: assert property (cfg_rd_en |=> cfg_rd_valid)
    else $error("read not answered");
  AST_RD_ONE: assert property (!cfg_rd_en |=> !cfg_rd_valid)
    else $error("stray read valid");
  AST_UNMAPPED: assert property (cfg_rd_en && cfg_addr != 8'h80
    |=> cfg_rdata == 32'h0) else $error("unmapped read not zero");
  AST_READBACK: assert property (cfg_rd_en && cfg_addr == 8'h80
    |=> cfg_rdata == $past(word_r)) else $error("readback wrong");
  AST_HIGH_SIDE: assert property (high_side_on != 3'h0 |->
    high_side_on == 3'h7 && low_side_on == 3'h0 && !word_r[21])
    else $error("high side brake wrong");
  AST_LOW_SIDE: assert property (low_side_on != 3'h0 |->
    low_side_on == 3'h7 && high_side_on == 3'h0 && word_r[21])
    else $error("low side brake wrong");
  AST_BRAKE_HIZ: assert property ((high_side_on | low_side_on) != 3'h0
    |-> !phase_hiz) else $error("floating while braking");
  AST_DONE: assert property (isd_done |-> !isd_busy && $past(isd_busy))
    else $error("done without sequence");
  AST_ONE_RESULT: assert property (!(motor_stationary && resync_ok))
    else $error("both results set");
endmodule

bind initial_speed_detect_config initial_speed_detect_config_props u_props (.sys_clk, .reset_n, .cfg_addr,
  .cfg_wr_en, .cfg_wdata, .cfg_rd_en, .cfg_rdata, .cfg_rd_valid,
  .high_side_on, .low_side_on, .phase_hiz, .isd_busy, .motor_stationary,
  .resync_ok, .isd_done);

// >>> test/isd_host_model.sv
// Host model that writes and reads the configuration word
module isd_host_model (
  // Clock
  input wire logic sys_clk,
  // Config bus
  output logic [7:0] cfg_addr,
  output logic cfg_wr_en,
  output logic [31:0] cfg_wdata,
  output logic cfg_rd_en
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cfg_addr = 8'h00;
    cfg_wr_en = 1'b0;
    cfg_wdata = 32'h0;
    cfg_rd_en = 1'b0;
  end
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = wr;
    cfg_rd_en = !wr;
    @(posedge sys_clk);
    #1;
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    // Idle data is inverted so a stale value cannot pass for a fresh one
    cfg_wdata = ~d;
  endtask
endmodule

// >>> test/initial_speed_detect_config_bench.sv
// Self-checking bench for the initial speed detect block
module initial_speed_detect_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, isd_start, cfg_wr_en, cfg_rd_en, cfg_rd_valid;
  logic phase_hiz, isd_busy, motor_stationary, resync_ok, isd_done;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, w;
  logic [6:0] motor_speed_pct;
  logic [10:0] backemf_mv, phase_current_ma;
  logic [2:0] high_side_on, low_side_on;
  logic [31:0] rq[$];
  logic [1:0] sq[$];
  logic [6:0] gq[$];
  logic [5:0] gate_seen = 6'h00;
  int bad_count, compares, seed, i, brk_cnt;
  // A full brake of the shortest duration at one cycle per ms
  localparam int BRK_MIN = 10;
  // Stationary, resync, high side brake, low side early current exit
  logic [31:0] tw[4] = '{32'h0000_01C0, 32'h0240_0000, 32'h0, 32'h003B_E000};
  logic [10:0] tb[4] = '{11'h5DB, 11'h032, 11'h7D0, 11'h7D0};
  logic [6:0] ts[4] = '{7'h00, 7'h32, 7'h04, 7'h04};
  logic [10:0] tc[4] = '{11'h000, 11'h000, 11'h000, 11'h7CF};
  logic [1:0] te[4] = '{2'h2, 2'h1, 2'h2, 2'h2};
  // Full brake seen, high side gates seen, low side gates seen
  logic [6:0] tg[4] = '{7'h00, 7'h00, 7'h78, 7'h07};

  isd_host_model host (.sys_clk, .cfg_addr, .cfg_wr_en, .cfg_wdata,
    .cfg_rd_en);
  initial_speed_detect_config #(.CYCLES_PER_MS(1)) dut (.sys_clk, .reset_n, .cfg_addr,
    .cfg_wr_en, .cfg_wdata, .cfg_rd_en, .cfg_rdata, .cfg_rd_valid,
    .isd_start, .motor_speed_pct, .backemf_mv, .phase_current_ma,
    .high_side_on, .low_side_on, .phase_hiz, .isd_busy, .motor_stationary,
    .resync_ok, .isd_done);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_res(input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_gate(input logic [6:0] e, input logic [6:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    host.access(1'b0, a, 32'h0);
  endtask
  // A brake that ignores the current exit outlasts this bound
  task automatic wait_done;
    int n;
    n = 0;
    while (isd_done !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (isd_done !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, 1'b1, isd_done);
      wrap_up();
    end
  endtask

  // Results are compared on the falling edge, where outputs have settled
  // Gates and brake length are gathered per sequence, cleared at its start
  always @(negedge sys_clk) begin
    if (isd_start === 1'b1) begin
      gate_seen = 6'h00;
      brk_cnt = 0;
    end
    gate_seen = gate_seen | {high_side_on, low_side_on};
    if ((high_side_on | low_side_on) != 3'h0) brk_cnt++;
    if (isd_done === 1'b1 && gq.size() > 0)
      chk_gate(gq.pop_front(), {brk_cnt >= BRK_MIN, gate_seen});
    if (cfg_rd_valid === 1'b1 && rq.size() > 0)
      chk_rd(rq.pop_front(), cfg_rdata);
    if (isd_done === 1'b1 && sq.size() > 0)
      chk_res(sq.pop_front(), {motor_stationary, resync_ok});
  end

  initial begin
    seed = 37434;
    reset_n = 1'b0;
    isd_start = 1'b0;
    motor_speed_pct = 7'h00;
    backemf_mv = 11'h000;
    phase_current_ma = 11'h000;
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    w = $random(seed);
    rd(8'h80, isd_pkg::CFG_RESET);
    host.access(1'b1, 8'h80, w);
    host.access(1'b1, 8'h84, ~w);
    rd(8'h84, 32'h0);
    rd(8'h80, w);
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      host.access(1'b1, 8'h80, tw[i]);
      backemf_mv = tb[i];
      motor_speed_pct = ts[i];
      phase_current_ma = tc[i];
      sq.push_back(te[i]);
      gq.push_back(tg[i]);
      isd_start = 1'b1;
      @(posedge sys_clk);
      #1;
      isd_start = 1'b0;
      wait_done();
      $display("sequence test %0d done", i);
    end
    repeat (2) @(posedge sys_clk);
    wrap_up();
  end
endmodule
